// File: design/sbrg_consts.svh
// Register offsets, field positions, reset values and timing constants of the baud rate generator
`ifndef SBRG_CONSTS_SVH
`define SBRG_CONSTS_SVH

// ==========================================================
// Register byte addresses
`define SBRG_ADDR_CONTROL 12'h000
`define SBRG_ADDR_DIV_LO 12'h004
`define SBRG_ADDR_DIV_HI 12'h008
`define SBRG_ADDR_MODE 12'h00c
`define SBRG_ADDR_STATUS 12'h010

// ==========================================================
// baud_control fields
`define SBRG_BIT_IDLE 6
`define SBRG_BIT_SYNC_CLOCK_POLARITY 4
`define SBRG_BIT_WIDE 3
`define SBRG_BIT_WAKE 1
`define SBRG_BIT_ABD 0
`define SBRG_CONTROL_RESET 8'h50
`define SBRG_CONTROL_WMASK 8'h1b

// ==========================================================
// Mode register fields
`define SBRG_BIT_SYNC 0
`define SBRG_BIT_HIGH_RATE_SELECT 1
`define SBRG_BIT_MASTER 2

// ==========================================================
// Status register fields
`define SBRG_BIT_WAKE_FLAG 0
`define SBRG_BIT_ABD_OVF 1

// ==========================================================
// Prescale counts
`define SBRG_PRE_ASYNC_LOW 8'd64
`define SBRG_PRE_ASYNC_HIGH 8'd16
`define SBRG_PRE_ASYNC_WIDE 8'd4
`define SBRG_PRE_SYNC 8'd4
`define SBRG_SYNC_BITS 8

`endif

// File: design/sbrg_pkg.sv
// Types shared by the baud rate generator modules
package sbrg_pkg;
   typedef enum logic [2:0] {
      SBRG_ABD_IDLE = 3'b000,
      SBRG_ABD_WAIT_START = 3'b001,
      SBRG_ABD_MEASURE = 3'b010,
      SBRG_ABD_DONE = 3'b011
   } sbrg_abd_state_t;
   typedef logic [15:0] sbrg_div_t;
endpackage

// File: design/sbrg_prescaler.sv
// Prescaler and divisor timer producing the baud tick
`timescale 1ns/1ns
`default_nettype none
`include "sbrg_consts.svh"
module sbrg_prescaler (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_restart,
   input wire logic i_enable,
   input wire logic [7:0] i_prescale,
   input wire sbrg_pkg::sbrg_div_t i_divisor,
   output logic o_tick
);
   import sbrg_pkg::*;
   logic [7:0] pre_reg;
   sbrg_div_t cnt_reg;
   logic tick_reg;
   logic pre_wrap;

   assign pre_wrap = (pre_reg >= i_prescale - 8'd1);
   assign o_tick = tick_reg;

   // ==========================================================
   // Prescaler counts system clocks
   always_ff @(posedge i_mclk) begin
      if (i_srst || i_restart || !i_enable) begin
         pre_reg <= 8'h00;
      end else if (pre_wrap) begin
         pre_reg <= 8'h00;
      end else begin
         pre_reg <= pre_reg + 8'd1;
      end
   end

   // ==========================================================
   // Free-running divisor timer, cleared on divisor write
   always_ff @(posedge i_mclk) begin
      if (i_srst || i_restart || !i_enable) begin
         cnt_reg <= 16'h0000;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= 1'b0;
         if (pre_wrap) begin
            if (cnt_reg >= i_divisor) begin
               cnt_reg <= 16'h0000;
               tick_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 16'd1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: design/sbrg_sync2.sv
// Two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
`default_nettype none
module sbrg_sync2 (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_async,
   output logic o_sync
);
   logic meta_reg;
   logic sync_reg;
   assign o_sync = sync_reg;
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// File: design/sbrg_top.sv
// Baud rate generator with its control registers behind an APB slave
// Operation
// - One generator, 8 or 16 bit, both modes
// - Reset selects 8-bit; wide bit selects 16
// - Divisor pair sets free-running timer period
// - Async uses high rate bit; sync ignores
// - Ticks only when master drives the clock
// - Divisor write clears the rate timer
// - Timing derived from the system clock
// - Sleep stops the clock and counting
// - Primary idle keeps generator clocked
// - Rates 64, 16, 4 times (n+1)
`timescale 1ns/1ns
`default_nettype none
`include "sbrg_consts.svh"
module sbrg_top (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_sleep,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_rx_pin,
   input wire logic i_rx_busy,
   output logic o_baud_tick,
   output logic o_sync_clock_polarity,
   output logic o_wake_irq
);
   import sbrg_pkg::*;

   logic [7:0] ctrl_reg;
   logic [7:0] div_lo_reg;
   logic [7:0] div_hi_reg;
   logic [2:0] mode_reg;
   logic wake_flag_reg;
   logic abd_ovf_reg;
   logic [31:0] rdata_reg;
   logic slverr_reg;
   logic wake_armed_reg;
   logic rx_prev_reg;
   sbrg_abd_state_t abd_state_reg;
   logic [2:0] abd_edges_reg;
   sbrg_div_t abd_cnt_reg;
   logic [4:0] abd_pre_reg;
   logic rx_s;
   logic access;
   logic wr;
   logic mapped;
   logic div_write;
   logic wide;
   logic sync_mode;
   logic high_rate_select;
   logic master;
   logic [7:0] prescale;
   sbrg_div_t divisor;
   logic gen_enable;
   logic rx_fall;
   logic rx_rise;
   logic abd_load;
   sbrg_div_t abd_result;
   logic sel_ctrl;
   logic sel_div_lo;
   logic sel_div_hi;
   logic sel_mode;
   logic sel_status;
   logic abd_active;

   // ==========================================================
   // Pin synchronisation
   sbrg_sync2 u_rx_sync (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_async(i_rx_pin),
      .o_sync(rx_s)
   );

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rx_prev_reg <= 1'b1;
      end else begin
         rx_prev_reg <= rx_s;
      end
   end
   assign rx_fall = rx_prev_reg && !rx_s;
   assign rx_rise = !rx_prev_reg && rx_s;

   // ==========================================================
   // APB decode
   assign access = i_psel && i_penable;
   assign wr = access && i_pwrite;
   assign sel_ctrl = (i_paddr == `SBRG_ADDR_CONTROL);
   assign sel_div_lo = (i_paddr == `SBRG_ADDR_DIV_LO);
   assign sel_div_hi = (i_paddr == `SBRG_ADDR_DIV_HI);
   assign sel_mode = (i_paddr == `SBRG_ADDR_MODE);
   assign sel_status = (i_paddr == `SBRG_ADDR_STATUS);
   assign mapped = sel_ctrl || sel_div_lo || sel_div_hi || sel_mode || sel_status;
   assign div_write = wr && (sel_div_lo || sel_div_hi);
   assign o_pready = 1'b1;
   assign o_prdata = rdata_reg;
   assign o_pslverr = slverr_reg;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rdata_reg <= 32'h0000_0000;
         slverr_reg <= 1'b0;
      end else begin
         slverr_reg <= 1'b0;
         if (i_psel && !i_penable) begin
            slverr_reg <= !mapped;
            unique case (i_paddr)
               `SBRG_ADDR_CONTROL: rdata_reg <= {24'h000000, ctrl_reg};
               `SBRG_ADDR_DIV_LO: rdata_reg <= {24'h000000, div_lo_reg};
               `SBRG_ADDR_DIV_HI: rdata_reg <= {24'h000000, div_hi_reg};
               `SBRG_ADDR_MODE: rdata_reg <= {29'h00000000, mode_reg};
               `SBRG_ADDR_STATUS: rdata_reg <= {30'h00000000, abd_ovf_reg, wake_flag_reg};
               default: rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // baud_control register
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ctrl_reg <= `SBRG_CONTROL_RESET;
      end else begin
         if (wr && i_paddr == `SBRG_ADDR_CONTROL) begin
            ctrl_reg[`SBRG_BIT_SYNC_CLOCK_POLARITY] <= i_pwdata[`SBRG_BIT_SYNC_CLOCK_POLARITY];
            ctrl_reg[`SBRG_BIT_WIDE] <= i_pwdata[`SBRG_BIT_WIDE];
            ctrl_reg[`SBRG_BIT_WAKE] <= i_pwdata[`SBRG_BIT_WAKE];
            ctrl_reg[`SBRG_BIT_ABD] <= i_pwdata[`SBRG_BIT_ABD];
         end
         ctrl_reg[`SBRG_BIT_IDLE] <= !i_rx_busy;
         if (wake_armed_reg && rx_rise) begin
            ctrl_reg[`SBRG_BIT_WAKE] <= 1'b0;
         end
         if (abd_load) begin
            ctrl_reg[`SBRG_BIT_ABD] <= 1'b0;
         end
      end
   end
   assign wide = ctrl_reg[`SBRG_BIT_WIDE];
   assign o_sync_clock_polarity = ctrl_reg[`SBRG_BIT_SYNC_CLOCK_POLARITY];

   // ==========================================================
   // Mode register: sync, high rate, master
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         mode_reg <= 3'h0;
      end else if (wr && i_paddr == `SBRG_ADDR_MODE) begin
         mode_reg <= i_pwdata[2:0];
      end
   end
   assign sync_mode = mode_reg[`SBRG_BIT_SYNC];
   assign high_rate_select = mode_reg[`SBRG_BIT_HIGH_RATE_SELECT];
   assign master = mode_reg[`SBRG_BIT_MASTER];

   // ==========================================================
   // Divisor bytes; auto-rate result overrides
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         div_lo_reg <= 8'h00;
         div_hi_reg <= 8'h00;
      end else if (abd_load) begin
         div_lo_reg <= abd_result[7:0];
         div_hi_reg <= abd_result[15:8];
      end else if (wr && i_paddr == `SBRG_ADDR_DIV_LO) begin
         div_lo_reg <= i_pwdata[7:0];
      end else if (wr && i_paddr == `SBRG_ADDR_DIV_HI) begin
         div_hi_reg <= i_pwdata[7:0];
      end
   end

   // ==========================================================
   // Rate selection
   always_comb begin
      if (sync_mode) begin
         prescale = `SBRG_PRE_SYNC;
      end else if (wide && high_rate_select) begin
         prescale = `SBRG_PRE_ASYNC_WIDE;
      end else if (wide || high_rate_select) begin
         prescale = `SBRG_PRE_ASYNC_HIGH;
      end else begin
         prescale = `SBRG_PRE_ASYNC_LOW;
      end
   end
   assign divisor = wide ? {div_hi_reg, div_lo_reg} : {8'h00, div_lo_reg};
   // Sleep gates the generator; primary idle leaves it counting
   assign abd_active = (abd_state_reg != SBRG_ABD_IDLE);
   assign gen_enable = master && !i_sleep && !abd_active;

   sbrg_prescaler u_prescaler (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_restart(div_write),
      .i_enable(gen_enable),
      .i_prescale(prescale),
      .i_divisor(divisor),
      .o_tick(o_baud_tick)
   );

   // ==========================================================
   // Wake on falling edge of the receive line
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         wake_armed_reg <= 1'b0;
         wake_flag_reg <= 1'b0;
      end else begin
         if (!ctrl_reg[`SBRG_BIT_WAKE] || sync_mode) begin
            wake_armed_reg <= 1'b0;
         end else if (rx_fall) begin
            wake_armed_reg <= 1'b1;
         end else if (rx_rise) begin
            wake_armed_reg <= 1'b0;
         end
         if (ctrl_reg[`SBRG_BIT_WAKE] && !sync_mode && rx_fall) begin
            wake_flag_reg <= 1'b1;
         end else if (wr && i_paddr == `SBRG_ADDR_STATUS && i_pwdata[`SBRG_BIT_WAKE_FLAG]) begin
            wake_flag_reg <= 1'b0;
         end
      end
   end
   assign o_wake_irq = wake_flag_reg;

   // ==========================================================
   // Auto-rate: time eight bits of the 55h field between falling edges
   // Counts in units of 16 clocks, so a result maps to the 16x prescale
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         abd_state_reg <= SBRG_ABD_IDLE;
         abd_edges_reg <= 3'h0;
         abd_cnt_reg <= 16'h0000;
         abd_pre_reg <= 5'h00;
         abd_ovf_reg <= 1'b0;
      end else begin
         if (wr && i_paddr == `SBRG_ADDR_STATUS && i_pwdata[`SBRG_BIT_ABD_OVF]) begin
            abd_ovf_reg <= 1'b0;
         end
         unique case (abd_state_reg)
            SBRG_ABD_IDLE: begin
               if (ctrl_reg[`SBRG_BIT_ABD] && !sync_mode) begin
                  abd_state_reg <= SBRG_ABD_WAIT_START;
               end
            end
            SBRG_ABD_WAIT_START: begin
               abd_cnt_reg <= 16'h0000;
               abd_pre_reg <= 5'h00;
               abd_edges_reg <= 3'h0;
               if (!ctrl_reg[`SBRG_BIT_ABD] || sync_mode) begin
                  abd_state_reg <= SBRG_ABD_IDLE;
               end else if (rx_fall) begin
                  abd_state_reg <= SBRG_ABD_MEASURE;
               end
            end
            SBRG_ABD_MEASURE: begin
               abd_pre_reg <= abd_pre_reg + 5'd1;
               if (abd_pre_reg == 5'd15) begin
                  abd_pre_reg <= 5'h00;
                  if (abd_cnt_reg == 16'hffff) begin
                     abd_ovf_reg <= 1'b1;
                  end else begin
                     abd_cnt_reg <= abd_cnt_reg + 16'd1;
                  end
               end
               if (rx_fall) begin
                  abd_edges_reg <= abd_edges_reg + 3'd1;
                  if (abd_edges_reg == 3'd3) begin
                     abd_state_reg <= SBRG_ABD_DONE;
                  end
               end
               // Clearing the enable or leaving async mode abandons the measurement
               if (!ctrl_reg[`SBRG_BIT_ABD] || sync_mode) begin
                  abd_state_reg <= SBRG_ABD_IDLE;
               end
            end
            SBRG_ABD_DONE: begin
               abd_state_reg <= SBRG_ABD_IDLE;
            end
            default: begin
               abd_state_reg <= SBRG_ABD_IDLE;
            end
         endcase
      end
   end
   assign abd_load = (abd_state_reg == SBRG_ABD_DONE);
   // Eight bit times counted: divisor = count/8 - 1
   assign abd_result = (abd_cnt_reg[15:3] == 13'h0000) ? 16'h0000 : {3'h0, abd_cnt_reg[15:3] - 13'd1};
endmodule
`default_nettype wire

// File: sim/sbrg_checker.sv
// Port assertions for the baud rate generator
`timescale 1ns/1ns
`default_nettype none
`include "sbrg_consts.svh"
module sbrg_checker (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_sleep,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_rx_pin,
   input wire logic i_rx_busy,
   input wire logic o_baud_tick,
   input wire logic o_sync_clock_polarity,
   input wire logic o_wake_irq
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   logic acc, wr, pol_w, mapped;
   assign acc = i_psel && i_penable;
   assign wr = acc && i_pwrite;
   assign pol_w = i_pwdata[4];
   assign mapped = i_paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
   tick_gap_a: assert property (o_baud_tick |=> !o_baud_tick [*3])
      else $error("baud ticks closer than four clocks");
   div_restart_a: assert property (wr && (i_paddr == `SBRG_ADDR_DIV_LO || i_paddr == `SBRG_ADDR_DIV_HI)
      |=> !o_baud_tick [*4])
      else $error("tick too soon after divisor write");
   sleep_stop_a: assert property (i_sleep |=> !o_baud_tick)
      else $error("tick while asleep");
   sleep_wake_a: assert property ($fell(i_sleep) |-> !o_baud_tick [*3])
      else $error("tick too soon after sleep");
   idle_flag_a: assert property (acc && !i_pwrite && i_paddr == `SBRG_ADDR_CONTROL
      |-> o_prdata[6] == !$past(i_rx_busy, 2))
      else $error("idle flag does not follow receiver");
   wake_hold_a: assert property (o_wake_irq && !(wr && i_paddr == `SBRG_ADDR_STATUS && i_pwdata[0])
      |=> o_wake_irq)
      else $error("wake request dropped uncleared");
   unmapped_err_a: assert property (acc |-> o_pslverr == !mapped)
      else $error("slave error does not match address map");
   ready_access_a: assert property (acc |-> o_pready)
      else $error("access phase not answered at once");
   polarity_a: assert property (wr && i_paddr == `SBRG_ADDR_CONTROL |=> o_sync_clock_polarity == $past(pol_w))
      else $error("polarity pin does not follow register");
endmodule
bind sbrg_top sbrg_checker chk_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_sleep(i_sleep), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rx_pin(i_rx_pin), .i_rx_busy(i_rx_busy),
   .o_baud_tick(o_baud_tick), .o_sync_clock_polarity(o_sync_clock_polarity), .o_wake_irq(o_wake_irq));
`default_nettype wire

// File: sim/sbrg_serial_partner.sv
// Receiver stand-in that sends one frame on the receive pin, paced by baud ticks
`timescale 1ns/1ns
`default_nettype none
module sbrg_serial_partner (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_tick,
   input wire logic i_send,
   input wire logic [7:0] i_data,
   input wire logic [7:0] i_bit_ticks,
   output logic o_rx_pin,
   output logic o_rx_busy
);
   logic [8:0] shift_reg;
   logic [3:0] bits_reg;
   logic [7:0] cnt_reg;
   // Start bit, eight data bits low first, stop bit; line idles high
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rx_pin <= 1'b1;
         o_rx_busy <= 1'b0;
         bits_reg <= 4'h0;
         cnt_reg <= 8'h00;
      end else if (i_send && !o_rx_busy) begin
         o_rx_pin <= 1'b0;
         o_rx_busy <= 1'b1;
         shift_reg <= {1'b1, i_data};
         bits_reg <= 4'h9;
         cnt_reg <= 8'h00;
      end else if (o_rx_busy && i_tick) begin
         cnt_reg <= cnt_reg + 8'h01;
         if (cnt_reg == i_bit_ticks - 8'h01) begin
            cnt_reg <= 8'h00;
            {shift_reg, o_rx_pin} <= {1'b1, shift_reg};
            bits_reg <= bits_reg - 4'h1;
            o_rx_busy <= (bits_reg != 4'h0);
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/serial_baud_rate_generator_test.sv
// Self-checking bench for the baud rate generator
`timescale 1ns/1ns
`default_nettype none
`include "sbrg_consts.svh"
module serial_baud_rate_generator_test;
   logic i_mclk = 1'b0, i_srst = 1'b1, i_sleep = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic o_pready, o_pslverr, o_baud_tick, o_sync_clock_polarity, o_wake_irq, i_rx_pin, i_rx_busy, err;
   logic send = 1'b0;
   logic pace = 1'b0;
   logic [7:0] bit_ticks = 8'h02;
   int fails = 0, cmp_count = 0, c;
   sbrg_top dut_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_sleep(i_sleep), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_rx_pin(i_rx_pin), .i_rx_busy(i_rx_busy), .o_baud_tick(o_baud_tick),
      .o_sync_clock_polarity(o_sync_clock_polarity), .o_wake_irq(o_wake_irq));
   sbrg_serial_partner part_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_tick(o_baud_tick || pace), .i_send(send),
      .i_data(8'h55), .i_bit_ticks(bit_ticks), .o_rx_pin(i_rx_pin), .o_rx_busy(i_rx_busy));
   initial begin
      forever #50 i_mclk = ~i_mclk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      @(posedge i_mclk);
      while (o_pready !== 1'b1) @(posedge i_mclk);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(negedge i_mclk);
         n++;
      end while (o_baud_tick !== 1'b1 && n < 20000);
   endtask
   task automatic count_ticks(input int n);
      @(posedge i_mclk);
      c = 0;
      repeat (n) begin
         @(negedge i_mclk);
         if (o_baud_tick === 1'b1) c++;
      end
   endtask
   task automatic frame_start();
      @(posedge i_mclk);
      send <= 1'b1;
      @(posedge i_mclk);
      send <= 1'b0;
   endtask
   task automatic frame_end();
      @(posedge i_mclk);
      c = 0;
      while (i_rx_busy !== 1'b0 && c < 4000) begin
         @(posedge i_mclk);
         c++;
      end
      check("frame ends", i_rx_busy, 1'b0);
   endtask
   // Mode bits: 0 sync, 1 high rate, 2 wide divider
   function automatic int period(input logic [2:0] m, input logic [7:0] hi, input logic [7:0] lo);
      int p;
      p = (m[0] || (m[1] && m[2])) ? 4 : (m[1] || m[2]) ? 16 : 64;
      return p * (int'(m[2] ? {hi, lo} : {8'h00, lo}) + 1);
   endfunction
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #5000000;
      fails++;
      report_and_stop();
   end
   initial begin
      logic [7:0] lo, hi;
      logic [2:0] m;
      int t;
      void'($urandom(20));
      repeat (4) @(posedge i_mclk);
      i_srst <= 1'b0;
      apb(1'b0, `SBRG_ADDR_CONTROL, 32'h0);
      check("control reset", rd, 32'h50);
      check("polarity reset", o_sync_clock_polarity, 1'b1);
      // Every mode combination with a random divisor, n = 0 first
      for (int i = 0; i < 8; i++) begin
         m = i[2:0];
         lo = (i == 0) ? 8'h00 : 8'($urandom_range(31));
         hi = 8'($urandom_range(1));
         apb(1'b1, `SBRG_ADDR_MODE, {29'h0, 1'b1, m[1], m[0]});
         apb(1'b1, `SBRG_ADDR_CONTROL, {28'h0, m[2], 3'b000});
         apb(1'b1, `SBRG_ADDR_DIV_HI, {24'h0, hi});
         apb(1'b1, `SBRG_ADDR_DIV_LO, {24'h0, lo});
         wait_tick(t);
         check("first tick", t, period(m, hi, lo) + 1);
         wait_tick(t);
         check("tick period", t, period(m, hi, lo));
      end
      apb(1'b1, `SBRG_ADDR_CONTROL, 32'hffffffea);
      apb(1'b0, `SBRG_ADDR_CONTROL, 32'h0);
      check("control masked", rd, 32'h4a);
      check("polarity pin", o_sync_clock_polarity, 1'b0);
      apb(1'b1, `SBRG_ADDR_DIV_HI, 32'h0);
      apb(1'b1, `SBRG_ADDR_DIV_LO, 32'h1);
      apb(1'b0, 12'h014, 32'h0);
      check("unmapped data", rd, 32'h0);
      check("unmapped error", err, 1'b1);
      apb(1'b1, `SBRG_ADDR_MODE, 32'h2);
      count_ticks(100);
      check("slave ticks", c, 0);
      apb(1'b0, `SBRG_ADDR_CONTROL, 32'h0);
      check("idle before sleep", rd[6], 1'b1);
      apb(1'b1, `SBRG_ADDR_MODE, 32'h6);
      i_sleep <= 1'b1;
      count_ticks(100);
      check("sleep ticks", c, 0);
      @(posedge i_mclk);
      i_sleep <= 1'b0;
      wait_tick(t);
      check("ticks resume", t, period(3'b110, 8'h00, 8'h01) + 1);
      // A received frame raises the wake request and lowers the idle flag
      frame_start();
      apb(1'b0, `SBRG_ADDR_CONTROL, 32'h0);
      check("idle flag busy", rd[6], 1'b0);
      frame_end();
      repeat (3) @(posedge i_mclk);
      check("wake request", o_wake_irq, 1'b1);
      apb(1'b0, `SBRG_ADDR_CONTROL, 32'h0);
      check("wake enable cleared", rd, 32'h48);
      apb(1'b1, `SBRG_ADDR_STATUS, 32'h1);
      repeat (2) @(negedge i_mclk);
      check("wake request cleared", o_wake_irq, 1'b0);
      // Auto-rate times a clock-paced 55h frame of 16*t clocks per bit
      t = $urandom_range(8, 2);
      bit_ticks <= 8'(16 * t);
      pace <= 1'b1;
      apb(1'b1, `SBRG_ADDR_CONTROL, 32'h1);
      frame_start();
      frame_end();
      apb(1'b0, `SBRG_ADDR_DIV_LO, 32'h0);
      check("auto divisor low", rd, 32'(t - 1));
      apb(1'b0, `SBRG_ADDR_DIV_HI, 32'h0);
      check("auto divisor high", rd, 32'h0);
      apb(1'b0, `SBRG_ADDR_CONTROL, 32'h0);
      check("auto enable cleared", rd, 32'h40);
      apb(1'b0, `SBRG_ADDR_STATUS, 32'h0);
      check("status clear", rd, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
